// ---- core/output_divider_delay_map.vh ----
// Register offsets, field positions and codes of the output divider and delay bank
`ifndef OUTPUT_DIVIDER_DELAY_MAP_VH
`define OUTPUT_DIVIDER_DELAY_MAP_VH

// Register offsets
`define OFS_OUTPUT_DELAY_SETTING      8'h34
`define OFS_OUTPUT_SUPPLY_DRIVER_TYPE 8'h35
`define OFS_OUTPUT_TERMINATION_SELECT 8'h37
`define OFS_DIVIDER_UPPER_NIBBLE      8'h38
`define OFS_DIVIDER_MIDDLE_BYTE       8'h39
`define OFS_DIVIDER_LOW_BYTE          8'h3a

// Reset value of every register and read value of unmapped offsets
`define REG_RESET_VALUE 8'h00
`define UNMAPPED_READ   8'h00

// Delay setting fields
`define COARSE_DELAY_MSB 5
`define COARSE_DELAY_LSB 0
`define FINE_DELAY_MSB 7
`define FINE_DELAY_LSB 6

// Supply and driver fields
`define SUPPLY_MSB 4
`define SUPPLY_LSB 3
`define DRIVER_MSB 2
`define DRIVER_LSB 0

// Termination register fields
`define FINE_DELAY_EXT_BIT 4
`define TERM_MSB 3
`define TERM_LSB 0

// Divider upper nibble field
`define DIV_UPPER_MSB 3
`define DIV_UPPER_LSB 0

// Supply level codes
`define SUPPLY_1V8 2'b00
`define SUPPLY_2V5 2'b01
`define SUPPLY_3V3 2'b10
`define SUPPLY_BAD 2'b11

// Driver standard codes
`define DRV_LVDS        3'h0
`define DRV_LVPECL_CM   3'h1
`define DRV_CML         3'h2
`define DRV_HCSL        3'h3
`define DRV_LVDS_BOOST  3'h4
`define DRV_LVPECL_NOCM 3'h5

// Termination codes, {neg cmos, pos cmos, pull up, pull down}
`define TERM_EXTERNAL 4'h0
`define TERM_PULL_UP  4'h2
`define TERM_PULL_DN  4'h1
`define TERM_CMOS_POS 4'h4
`define TERM_CMOS_NEG 4'h8
`define TERM_CMOS_BOTH 4'hc

// Fine delay step size and largest step count
`define FINE_STEP_PS  9'h01e
`define FINE_MAX_STEPS 3'h4

`endif

// ---- core/output_divider_delay_config.v ----
// Register bank for one clock output: divider, delay and driver settings
//
// Notes on behaviour
// (RL1) Divider bits 19:16 from upper register nibble
// (RL2) Divider bits 15:8 from middle register
// (RL3) Divider bits 7:0 from low register
// (RL4) Coarse delay 0 to 63 VCO periods
// (RL5) Two fine delay bits, 30 ps steps
// (RL6) Extended three-bit fine code, up to four
// (RL7) Supply code: 1.8, 2.5, 3.3 V
// (RL8) Decode six driver standard codes
// (RL9) Decode termination and single-ended pin modes
// (RL10) Software sets driver strength to seven; this bank has no strength field, offset 8'h33 is unmapped
// (RL11) Fields reset zero, read back written value
`timescale 1ns/1ns
`default_nettype none
`include "output_divider_delay_map.vh"

module output_divider_delay_config
(
  input wire mclk,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  output reg [19:0] output_divide_ratio,
  output reg [5:0] coarse_delay_periods,
  output reg [2:0] output_delay_code,
  output reg [2:0] fine_delay_steps,
  output reg [8:0] fine_delay_ps,
  output reg supply_1v8,
  output reg supply_2v5,
  output reg supply_3v3,
  output reg supply_code_bad,
  output reg drv_lvds,
  output reg drv_lvpecl_cm,
  output reg drv_cml,
  output reg drv_hcsl,
  output reg drv_lvds_boost,
  output reg drv_lvpecl_nocm,
  output reg driver_code_bad,
  output reg term_external,
  output reg term_pull_up,
  output reg term_pull_dn,
  output reg positive_output_pin_cmos,
  output reg negative_output_pin_cmos,
  output reg term_code_bad
);

  reg [7:0] output_delay_setting_r;
  reg [7:0] output_supply_driver_type_r;
  reg [7:0] output_termination_select_r;
  reg [7:0] divider_upper_nibble_r;
  reg [7:0] divider_middle_byte_r;
  reg [7:0] divider_low_byte_r;
  reg [7:0] rd_data_nxt;
  reg [2:0] delay_code_nxt;
  reg [2:0] fine_steps_nxt;
  reg [11:0] fine_ps_full_nxt;
  wire [1:0] supply_level_code;
  wire [2:0] driver_standard_code;
  wire [3:0] term_code;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  // (RL11) Zero reset, plain storage
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      output_delay_setting_r <= `REG_RESET_VALUE;
      output_supply_driver_type_r <= `REG_RESET_VALUE;
      output_termination_select_r <= `REG_RESET_VALUE;
      divider_upper_nibble_r <= `REG_RESET_VALUE;
      divider_middle_byte_r <= `REG_RESET_VALUE;
      divider_low_byte_r <= `REG_RESET_VALUE;
    end
    else if (wr_en)
    begin
      if (addr == `OFS_OUTPUT_DELAY_SETTING)
        output_delay_setting_r <= wr_data;
      else if (addr == `OFS_OUTPUT_SUPPLY_DRIVER_TYPE)
        output_supply_driver_type_r <= wr_data;
      else if (addr == `OFS_OUTPUT_TERMINATION_SELECT)
        output_termination_select_r <= wr_data;
      else if (addr == `OFS_DIVIDER_UPPER_NIBBLE)
        divider_upper_nibble_r <= wr_data;
      else if (addr == `OFS_DIVIDER_MIDDLE_BYTE)
        divider_middle_byte_r <= wr_data;
      else if (addr == `OFS_DIVIDER_LOW_BYTE)
        divider_low_byte_r <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped offsets read zero
  // (RL11) Read back stored value
  always @*
  begin
    if (addr == `OFS_OUTPUT_DELAY_SETTING)
      rd_data_nxt = output_delay_setting_r;
    else if (addr == `OFS_OUTPUT_SUPPLY_DRIVER_TYPE)
      rd_data_nxt = output_supply_driver_type_r;
    else if (addr == `OFS_OUTPUT_TERMINATION_SELECT)
      rd_data_nxt = output_termination_select_r;
    else if (addr == `OFS_DIVIDER_UPPER_NIBBLE)
      rd_data_nxt = divider_upper_nibble_r;
    else if (addr == `OFS_DIVIDER_MIDDLE_BYTE)
      rd_data_nxt = divider_middle_byte_r;
    else if (addr == `OFS_DIVIDER_LOW_BYTE)
      rd_data_nxt = divider_low_byte_r;
    else
      rd_data_nxt = `UNMAPPED_READ;
  end

  // Read data register, held between reads
  // (RL11) Registered read data
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      rd_data <= `UNMAPPED_READ;
    else if (rd_en)
      rd_data <= rd_data_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction
  // (RL7) Supply code slice
  assign supply_level_code = output_supply_driver_type_r[`SUPPLY_MSB:`SUPPLY_LSB];
  // (RL8) Driver code slice
  assign driver_standard_code = output_supply_driver_type_r[`DRIVER_MSB:`DRIVER_LSB];
  // (RL9) Termination code slice
  assign term_code = output_termination_select_r[`TERM_MSB:`TERM_LSB];

  // Fine delay code and step count, codes above four clamp to four
  always @*
  begin
    // (RL6) Extended top bit
    delay_code_nxt = {output_termination_select_r[`FINE_DELAY_EXT_BIT],
                      output_delay_setting_r[`FINE_DELAY_MSB:`FINE_DELAY_LSB]};
    // (RL6) Clamp above four steps
    if (delay_code_nxt > `FINE_MAX_STEPS)
      fine_steps_nxt = `FINE_MAX_STEPS;
    else
      fine_steps_nxt = delay_code_nxt;
    // (RL5) Steps times step size, full width
    fine_ps_full_nxt = fine_steps_nxt * `FINE_STEP_PS;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered decode of settings
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      output_divide_ratio <= 20'h00000;
      coarse_delay_periods <= 6'h00;
      output_delay_code <= 3'h0;
      fine_delay_steps <= 3'h0;
      fine_delay_ps <= 9'h000;
      supply_1v8 <= 1'b0;
      supply_2v5 <= 1'b0;
      supply_3v3 <= 1'b0;
      supply_code_bad <= 1'b0;
      drv_lvds <= 1'b0;
      drv_lvpecl_cm <= 1'b0;
      drv_cml <= 1'b0;
      drv_hcsl <= 1'b0;
      drv_lvds_boost <= 1'b0;
      drv_lvpecl_nocm <= 1'b0;
      driver_code_bad <= 1'b0;
      term_external <= 1'b0;
      term_pull_up <= 1'b0;
      term_pull_dn <= 1'b0;
      positive_output_pin_cmos <= 1'b0;
      negative_output_pin_cmos <= 1'b0;
      term_code_bad <= 1'b0;
    end
    else
    begin
      // (RL1) Upper divide bits
      output_divide_ratio[19:16] <= divider_upper_nibble_r[`DIV_UPPER_MSB:`DIV_UPPER_LSB];
      // (RL2) Middle divide bits
      output_divide_ratio[15:8] <= divider_middle_byte_r;
      // (RL3) Low divide bits
      output_divide_ratio[7:0] <= divider_low_byte_r;
      // (RL4) Coarse delay periods
      coarse_delay_periods <= output_delay_setting_r[`COARSE_DELAY_MSB:`COARSE_DELAY_LSB];
      // (RL5) Fine delay in steps
      output_delay_code <= delay_code_nxt;
      fine_delay_steps <= fine_steps_nxt;
      // (RL5) Fine delay in picoseconds, at most 120
      fine_delay_ps <= fine_ps_full_nxt[8:0];
      // (RL7) Supply level decode
      supply_1v8 <= (supply_level_code == `SUPPLY_1V8);
      supply_2v5 <= (supply_level_code == `SUPPLY_2V5);
      supply_3v3 <= (supply_level_code == `SUPPLY_3V3);
      // (RL7) Reserved supply code flagged
      supply_code_bad <= (supply_level_code == `SUPPLY_BAD);
      // (RL8) Driver standard decode
      drv_lvds <= (driver_standard_code == `DRV_LVDS);
      drv_lvpecl_cm <= (driver_standard_code == `DRV_LVPECL_CM);
      drv_cml <= (driver_standard_code == `DRV_CML);
      drv_hcsl <= (driver_standard_code == `DRV_HCSL);
      drv_lvds_boost <= (driver_standard_code == `DRV_LVDS_BOOST);
      drv_lvpecl_nocm <= (driver_standard_code == `DRV_LVPECL_NOCM);
      driver_code_bad <= (driver_standard_code > `DRV_LVPECL_NOCM);
      // (RL9) Termination and pin modes
      term_external <= (term_code == `TERM_EXTERNAL);
      term_pull_up <= (term_code == `TERM_PULL_UP);
      term_pull_dn <= (term_code == `TERM_PULL_DN);
      positive_output_pin_cmos <= (term_code == `TERM_CMOS_POS) || (term_code == `TERM_CMOS_BOTH);
      negative_output_pin_cmos <= (term_code == `TERM_CMOS_NEG) || (term_code == `TERM_CMOS_BOTH);
      term_code_bad <= (term_code != `TERM_EXTERNAL) && (term_code != `TERM_PULL_UP) &&
                       (term_code != `TERM_PULL_DN) && (term_code != `TERM_CMOS_POS) &&
                       (term_code != `TERM_CMOS_NEG) && (term_code != `TERM_CMOS_BOTH);
    end
  end

endmodule
`default_nettype wire

// ---- testbench/output_divider_delay_monitor.sv ----
// Checker for the output divider and delay bank
`timescale 1ns/1ns
`default_nettype none
module output_divider_delay_monitor
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [19:0] output_divide_ratio,
  input wire logic [2:0] output_delay_code,
  input wire logic [5:0] coarse_delay_periods,
  input wire logic [2:0] fine_delay_steps,
  input wire logic [8:0] fine_delay_ps,
  input wire logic supply_1v8,
  input wire logic supply_2v5,
  input wire logic supply_3v3,
  input wire logic supply_code_bad
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Fields follow a write two edges later
  div_upper_a: assert property (wr_en && addr == 8'h38 |=> ##1
    output_divide_ratio[19:16] == $past(wr_data[3:0], 2)) else $error("divider upper wrong");
  div_middle_a: assert property (wr_en && addr == 8'h39 |=> ##1
    output_divide_ratio[15:8] == $past(wr_data, 2)) else $error("divider middle wrong");
  div_low_a: assert property (wr_en && addr == 8'h3a |=> ##1
    output_divide_ratio[7:0] == $past(wr_data, 2)) else $error("divider low wrong");
  coarse_delay_a: assert property (wr_en && addr == 8'h34 |=> ##1
    coarse_delay_periods == $past(wr_data[5:0], 2)) else $error("coarse delay wrong");
  supply_decode_a: assert property (wr_en && addr == 8'h35 |=> ##1
    {supply_code_bad, supply_3v3, supply_2v5, supply_1v8} == 4'h1 << $past(wr_data[4:3], 2))
    else $error("supply decode wrong");
  // Settled fine code gives clamped steps of 30 ps
  fine_delay_a: assert property ($stable(output_delay_code) [*3] |->
    fine_delay_steps == (output_delay_code > 3'h4 ? 3'h4 : output_delay_code)
    && fine_delay_ps == 9'h01e * fine_delay_steps) else $error("fine delay wrong");
  // Read-back and unmapped reads
  read_back_a: assert property (wr_en && addr == 8'h39 ##1 rd_en && !wr_en && addr == 8'h39
    |=> rd_data == $past(wr_data, 2)) else $error("read back wrong");
  unmapped_read_a: assert property (rd_en && addr == 8'h36
    |=> rd_data == 8'h00) else $error("unmapped read wrong");
endmodule
bind output_divider_delay_config output_divider_delay_monitor output_divider_delay_monitor_inst (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Bench for the output divider and delay bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk, rst, wr_en, rd_en;
  logic [7:0] addr, wr_data, rd_data;
  logic [19:0] output_divide_ratio;
  logic [5:0] coarse_delay_periods;
  logic [2:0] output_delay_code, fine_delay_steps;
  logic [8:0] fine_delay_ps;
  wire [3:0] sup;
  wire [6:0] drv;
  wire [5:0] term;
  logic [7:0] regs [6] = '{8'h34, 8'h35, 8'h37, 8'h38, 8'h39, 8'h3a};
  logic [3:0] tc [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'h3};
  logic [5:0] te [7] = '{6'h01, 6'h04, 6'h02, 6'h08, 6'h10, 6'h18, 6'h20};
  int fails = 0;
  int n_compared = 0;
  output_divider_delay_config output_divider_delay_config_inst (.mclk(mclk), .rst(rst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .output_divide_ratio(output_divide_ratio),
    .coarse_delay_periods(coarse_delay_periods), .output_delay_code(output_delay_code),
    .fine_delay_steps(fine_delay_steps), .fine_delay_ps(fine_delay_ps), .supply_1v8(sup[0]), .supply_2v5(sup[1]),
    .supply_3v3(sup[2]), .supply_code_bad(sup[3]), .drv_lvds(drv[0]), .drv_lvpecl_cm(drv[1]), .drv_cml(drv[2]),
    .drv_hcsl(drv[3]), .drv_lvds_boost(drv[4]), .drv_lvpecl_nocm(drv[5]), .driver_code_bad(drv[6]),
    .term_external(term[0]), .term_pull_up(term[1]), .term_pull_dn(term[2]), .positive_output_pin_cmos(term[3]),
    .negative_output_pin_cmos(term[4]), .term_code_bad(term[5]));
  ////////////////////////////////////////
  // Clock at 100 ns period
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Compare and count
  task chk(string n, logic [19:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Host port accesses, driven at the falling edge
  task wr(logic [7:0] a, d);
    @(negedge mclk);
    {wr_en, rd_en, addr, wr_data} = {2'b10, a, d};
  endtask
  task rd(logic [7:0] a, e);
    @(negedge mclk);
    {wr_en, rd_en, addr} = {2'b01, a};
    @(posedge mclk);
    #1 chk("rd_data", e, rd_data);
  endtask
  task idle;
    @(negedge mclk);
    {wr_en, rd_en} = 2'b00;
    @(negedge mclk);
  endtask
  task test_done;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst, wr_en, rd_en, addr, wr_data} = {3'h4, 16'h0000};
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    idle;
    chk("defaults", 17'h02041, {sup, drv, term}); // zero codes
    foreach (regs[i]) rd(regs[i], 8'h00); // reset zero
    foreach (regs[i])
    begin
      wr(regs[i], regs[i] ^ 8'hc3); // write each
      rd(regs[i], regs[i] ^ 8'hc3); // read back
    end
    $display("test registers done");
    wr(8'h38, 8'hf5); // upper nibble
    wr(8'h39, 8'h3c); // middle byte
    wr(8'h3a, 8'h81); // low byte
    idle;
    chk("divider", 20'h53c81, output_divide_ratio); // ratio
    $display("test divider done");
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h34, {k[1:0], {6{k[0]}}}); // coarse and fine
      wr(8'h37, {3'h0, k[2], 4'h0}); // extended bit
      wr(8'h35, {3'h0, k[1:0], k[2:0]}); // supply and driver
      idle;
      chk("coarse", {6{k[0]}}, coarse_delay_periods); // both ends
      chk("delay code", k, output_delay_code); // three-bit code
      chk("fine steps", k > 4 ? 4 : k, fine_delay_steps); // clamped steps
      chk("fine ps", (k > 4 ? 4 : k) * 30, fine_delay_ps); // steps times 30 ps
      chk("supply", 4'h1 << k[1:0], sup); // supply codes
      chk("driver", k < 6 ? 7'h01 << k : 7'h40, drv); // driver codes
    end
    foreach (tc[i])
    begin
      wr(8'h37, {4'h0, tc[i]}); // termination code
      idle;
      chk("term", te[i], term); // pin modes
    end
    $display("test decode done");
    wr(8'h33, 8'h07); // strength seven, outside bank
    rd(8'h33, 8'h00); // not stored here
    wr(8'h36, 8'hff); // refused write
    rd(8'h36, 8'h00); // unmapped zero
    rd(8'h37, 8'h03); // neighbour kept
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    rd(8'h39, 8'h00); // reset clears
    $display("test refusal and reset done");
    test_done;
  end
endmodule
`default_nettype wire
